// file: verilog/smpp_top.sv
// Serial memory programming port, device side
`timescale 1ns/1ns
// Summary of operation
// - With reset low, refuse program and erase until programming enable is taken.
// - Sample MOSI on SCK rising edge, shift MISO on SCK falling edge.
// - Program space 0x000-0xFFF words and data space 0x000-0x1FF are separate.
// - Chip erase sets every program and data location to 0xFF.
// - Data byte write is self-timed and erases the location first.
// - Second byte 0x53 echoes on MISO during the third enable byte.
// - Data byte being written reads 0x00, then 0xFF, then the value.
// - Program byte being written reads 0xFF until written value is ready.
// - Program read/write opcodes carry H, 12-bit word address, data byte four.
// - Data read/write opcodes carry nine-bit address, data in byte four.
// - Programming enable is AC 53, last bytes ignored, only with reset low.
// - Lock and fuse read returns lock1, lock2, serial enable, startup fuse.
// - Lock bit write programs each lock bit sent as zero.
// - Startup fuse write programs on zero, unprograms on one.
// - Signature read returns indexed byte, hidden when both locks programmed.
module smpp_top
  import smpp_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic SERIAL_PROG_ENABLE_FUSE = 1'b0,
  // Signature values are arbitrary
  parameter logic [7:0] SIG0 = 8'hA5,
  parameter logic [7:0] SIG1 = 8'h5A,
  parameter logic [7:0] SIG2 = 8'h3C
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Programming link pins
  input wire logic sck_pin,
  input wire logic mosi_pin,
  input wire logic chip_reset_n,
  output logic miso_o,
  output logic miso_oe,
  // Status
  output logic prog_enabled,
  output logic write_busy,
  output logic [1:0] lock_bits,
  output logic fast_startup_fuse,
  output logic cmd_overrun
);
  localparam int MAXC = ERASE_CYC > WRITE_CYC ? ERASE_CYC : WRITE_CYC;
  localparam int WAIT_W = $clog2(MAXC + 1);
  localparam int HALF = WRITE_CYC / 2;

  // ==========================================================
  // Pin synchronisers
  logic sck_s;
  logic mosi_s;
  logic rstp_s;

  smpp_sync #(.W(3), .RST(3'h4)) u_sync (
    .clk(core_clk),
    .nrst(nrst),
    .din({chip_reset_n, sck_pin, mosi_pin}),
    .dout({rstp_s, sck_s, mosi_s})
  );

  // ==========================================================
  // Link shifter
  logic sck_d_r;
  logic [4:0] bit_cnt_r;
  logic [31:0] rx_r;
  logic [7:0] tx_r;
  logic miso_r;
  logic miso_oe_r;
  logic enabled_r;
  logic overrun_r;

  wire prog_mode = !rstp_s;
  wire sck_rise = prog_mode && sck_s && !sck_d_r;
  wire sck_fall = prog_mode && !sck_s && sck_d_r;
  wire [31:0] rx_nxt = {rx_r[30:0], mosi_s};
  wire byte_end = sck_rise && (bit_cnt_r[2:0] == 3'h7);
  wire instr_done = sck_rise && (bit_cnt_r == 5'h1F);
  smpp_instr_s rcv;
  assign rcv = rx_nxt;

  // ==========================================================
  // Read path, decoded at end of byte three
  smpp_state_e st_r;
  smpp_state_e st_nxt;
  logic [IDX_W-1:0] cur_idx_r;
  logic [7:0] pmem [PMEM_BYTES];
  logic [7:0] dmem [DMEM_BYTES];
  logic [1:0] lock_r;
  logic fast_startup_fuse_r;

  wire [7:0] q_op = rx_nxt[23:16];
  wire [7:0] q_b2 = rx_nxt[15:8];
  wire [7:0] q_b3 = rx_nxt[7:0];
  wire [IDX_W-1:0] q_pidx = {q_b2[3:0], q_b3, q_op[3]};
  wire [DADDR_W-1:0] q_didx = {q_b2[0], q_b3};
  wire q_prd = (q_op[7:4] == OP_PRD) && (q_op[2:0] == OP_PLOW);
  wire q_drd = q_op == OP_DRD;
  wire q_frd = q_op == OP_FRD;
  wire q_sig = q_op == OP_SIG;
  wire p_hit = (st_r == ST_PWR) && (cur_idx_r == q_pidx);
  wire d_ers_hit = (st_r == ST_DERS) && (cur_idx_r[DADDR_W-1:0] == q_didx);
  wire d_wr_hit = (st_r == ST_DWR) && (cur_idx_r[DADDR_W-1:0] == q_didx);
  wire locked = lock_r == 2'h0;
  wire [7:0] sig_byte = (q_b3[1:0] == 2'h0) ? SIG0 :
                        (q_b3[1:0] == 2'h1) ? SIG1 :
                        (q_b3[1:0] == 2'h2) ? SIG2 : SIG_NONE;
  wire [7:0] p_byte = p_hit ? POLL_VALUE_ERASED : pmem[q_pidx];
  wire [7:0] d_byte = d_ers_hit ? POLL_VALUE_ERASING :
                      d_wr_hit ? POLL_VALUE_ERASED : dmem[q_didx];
  wire [7:0] f_byte = {lock_r[0], lock_r[1], SERIAL_PROG_ENABLE_FUSE, FUSE_FILL, fast_startup_fuse_r};
  wire [7:0] s_byte = locked ? SIG_HIDDEN : sig_byte;
  wire [7:0] rd_byte = q_prd ? p_byte :
                       q_drd ? d_byte :
                       q_frd ? f_byte :
                       q_sig ? s_byte : q_b3;
  wire [7:0] tx_load = (bit_cnt_r[4:3] == 2'h2) ? rd_byte : rx_nxt[7:0];

  // ==========================================================
  // Instruction classification
  wire i_spec = rcv.op == OP_SPECIAL;
  wire i_en = i_spec && (rcv.b2 == B2_ENABLE);
  wire i_ers = i_spec && (rcv.b2[7:5] == B2_ERASE);
  wire i_lck = i_spec && (rcv.b2[7:3] == B2_LOCK_HI) && rcv.b2[0];
  wire i_fus = i_spec && (rcv.b2[7:1] == B2_FUSE);
  wire i_pwr = (rcv.op[7:4] == OP_PWR) && (rcv.op[2:0] == OP_PLOW);
  wire i_dwr = rcv.op == OP_DWR;
  wire i_mod = i_ers || i_lck || i_fus || i_pwr || i_dwr;
  wire en_hit = instr_done && i_en;
  wire push_req = instr_done && enabled_r && i_mod;
  logic fifo_ready;
  wire fifo_push = push_req && fifo_ready;

  smpp_cmd_s cmd_in;
  assign cmd_in.kind = i_ers ? CMD_ERASE :
                       i_lck ? CMD_LOCK :
                       i_fus ? CMD_FUSE :
                       i_pwr ? CMD_PWR : CMD_DWR;
  assign cmd_in.addr = i_dwr ? {4'h0, rcv.b2[0], rcv.b3} :
                               {rcv.b2[3:0], rcv.b3, rcv.op[3]};
  assign cmd_in.data = i_spec ? rcv.b2 : rcv.b4;

  always_ff @(posedge core_clk) begin
    if (!nrst || !prog_mode) begin
      sck_d_r <= 1'b0;
      bit_cnt_r <= 5'h0;
      rx_r <= 32'h0;
      tx_r <= 8'h0;
      miso_r <= 1'b0;
      enabled_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      if (sck_rise) begin
        rx_r <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 5'h1;
      end
      if (byte_end) begin
        tx_r <= tx_load;
      end else if (sck_fall) begin
        miso_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
      if (en_hit) begin
        enabled_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      miso_oe_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      miso_oe_r <= prog_mode;
      overrun_r <= prog_mode && (overrun_r || (push_req && !fifo_ready));
    end
  end

  // ==========================================================
  // Command FIFO
  logic head_valid;
  logic [$bits(smpp_cmd_s)-1:0] head_bits;
  smpp_cmd_s head;
  assign head = smpp_cmd_s'(head_bits);
  wire pop = head_valid && (st_r == ST_IDLE);

  smpp_fifo #(.WIDTH($bits(smpp_cmd_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(push_req),
    .in_ready(fifo_ready),
    .in_data(cmd_in),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head_bits)
  );

  // ==========================================================
  // Executor
  logic [WAIT_W-1:0] wait_r;
  logic [7:0] cur_data_r;
  logic busy_r;
  wire wait_done = wait_r == '0;
  wire pop_ers = pop && (head.kind == CMD_ERASE);
  wire [WAIT_W-1:0] wait_load = (head.kind == CMD_ERASE) ? WAIT_W'(ERASE_CYC - 1) :
                                (head.kind == CMD_DWR) ? WAIT_W'(HALF - 1) :
                                WAIT_W'(WRITE_CYC - 1);
  wire [WAIT_W-1:0] wait_rest = WAIT_W'(WRITE_CYC - HALF - 1);
  wire [DADDR_W-1:0] cur_didx = cur_idx_r[DADDR_W-1:0];

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (pop && head.kind == CMD_ERASE) begin
          st_nxt = ST_CERS;
        end else if (pop && head.kind == CMD_PWR) begin
          st_nxt = ST_PWR;
        end else if (pop && head.kind == CMD_DWR) begin
          st_nxt = ST_DERS;
        end
      end
      ST_DERS: st_nxt = wait_done ? ST_DWR : ST_DERS;
      ST_PWR, ST_DWR, ST_CERS: st_nxt = wait_done ? ST_IDLE : st_r;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (pop_ers) begin
      for (int i = 0; i < PMEM_BYTES; i++) begin
        pmem[i] <= ERASED;
      end
      for (int i = 0; i < DMEM_BYTES; i++) begin
        dmem[i] <= ERASED;
      end
    end
    if (st_r == ST_PWR && wait_done) begin
      pmem[cur_idx_r] <= cur_data_r;
    end
    if (st_r == ST_DERS && wait_done) begin
      dmem[cur_didx] <= ERASED;
    end
    if (st_r == ST_DWR && wait_done) begin
      dmem[cur_didx] <= cur_data_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      cur_idx_r <= '0;
      cur_data_r <= 8'h0;
      busy_r <= 1'b0;
      lock_r <= LOCK_RST;
      fast_startup_fuse_r <= FAST_STARTUP_FUSE_RST;
    end else begin
      st_r <= st_nxt;
      busy_r <= st_nxt != ST_IDLE;
      if (pop) begin
        cur_idx_r <= head.addr;
        cur_data_r <= head.data;
        wait_r <= wait_load;
      end else if (st_r == ST_DERS && wait_done) begin
        wait_r <= wait_rest;
      end else if (!wait_done) begin
        wait_r <= wait_r - 1'b1;
      end
      if (pop && head.kind == CMD_LOCK) begin
        lock_r <= lock_r & {head.data[2], head.data[1]};
      end
      if (pop && head.kind == CMD_FUSE) begin
        fast_startup_fuse_r <= head.data[0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign miso_o = miso_r;
  assign miso_oe = miso_oe_r;
  assign prog_enabled = enabled_r;
  assign write_busy = busy_r;
  assign lock_bits = lock_r;
  assign fast_startup_fuse = fast_startup_fuse_r;
  assign cmd_overrun = overrun_r;

  // ==========================================================
  // Assertions
  wire rd_load = byte_end && (bit_cnt_r == 5'h17);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_refuse_before_enable: assert property ((instr_done && !enabled_r && !head_valid) |=>
    !head_valid) else $error("command queued before enable");
  a_mosi_rise_sample: assert property (sck_rise |=> rx_r[0] == $past(mosi_s))
    else $error("MOSI not sampled on rise");
  a_miso_fall_shift: assert property (sck_fall |=> miso_r == $past(tx_r[7]))
    else $error("MISO not shifted on fall");
  a_echo_second_byte: assert property ((byte_end && bit_cnt_r == 5'h0F) |=>
    tx_r == $past(rx_nxt[7:0])) else $error("second byte not echoed");
  a_enable_on_reset_low: assert property ($rose(enabled_r) |-> $past(en_hit))
    else $error("enable without enable instruction");
  a_erase_fills_ff: assert property (pop_ers |=>
    pmem[0] == ERASED && dmem[DMEM_BYTES-1] == ERASED) else $error("erase left data");
  a_data_poll_zero: assert property ((rd_load && q_drd && d_ers_hit) |=>
    tx_r == 8'h00) else $error("data poll not zero while erasing");
  a_flash_poll_ff: assert property ((rd_load && q_prd && p_hit) |=>
    tx_r == 8'hFF) else $error("flash poll not FF");
  a_sig_hidden: assert property ((rd_load && q_sig && locked) |=>
    tx_r == 8'h00) else $error("signature visible when locked");
  a_unknown_ignored: assert property ((instr_done && !i_mod && !head_valid) |=>
    !head_valid) else $error("unknown instruction queued");
  a_fuse_write: assert property ((pop && head.kind == CMD_FUSE) |=>
    fast_startup_fuse_r == $past(head.data[0])) else $error("startup fuse not written");

  c_enabled: cover property ($rose(enabled_r));
  c_data_written: cover property (st_r == ST_DWR && wait_done);
  c_chip_erase: cover property (pop_ers);
  c_fifo_full: cover property (push_req && !fifo_ready);
endmodule

// file: pkg/smpp_pkg.sv
// Constants and types of the serial memory programming port
package smpp_pkg;

  // ==========================================================
  // Instruction encodings
  localparam logic [7:0] OP_SPECIAL = 8'hAC;
  localparam logic [7:0] B2_ENABLE = 8'h53;
  localparam logic [2:0] B2_ERASE = 3'h4;
  localparam logic [4:0] B2_LOCK_HI = 5'h1F;
  localparam logic [6:0] B2_FUSE = 7'h5F;
  localparam logic [3:0] OP_PRD = 4'h2;
  localparam logic [3:0] OP_PWR = 4'h4;
  localparam logic [2:0] OP_PLOW = 3'h0;
  localparam logic [7:0] OP_DRD = 8'hA0;
  localparam logic [7:0] OP_DWR = 8'hC0;
  localparam logic [7:0] OP_FRD = 8'h58;
  localparam logic [7:0] OP_SIG = 8'h30;

  // ==========================================================
  // Data values
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] POLL_VALUE_ERASING = 8'h00;
  localparam logic [7:0] POLL_VALUE_ERASED = 8'hFF;
  localparam logic [7:0] SIG_HIDDEN = 8'h00;
  localparam logic [7:0] SIG_NONE = 8'h00;
  localparam logic [3:0] FUSE_FILL = 4'hF;
  localparam logic [1:0] LOCK_RST = 2'h3;
  localparam logic FAST_STARTUP_FUSE_RST = 1'b1;

  // ==========================================================
  // Array sizes
  localparam int PADDR_W = 12;
  localparam int DADDR_W = 9;
  localparam int PMEM_BYTES = 8192;
  localparam int DMEM_BYTES = 512;
  localparam int IDX_W = 13;
  localparam int FIFO_DEPTH_DEF = 16;

  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 100000;
  localparam int WRITE_WAIT_DELAY_MS = 4;
  localparam int ERASE_WAIT_DELAY_MS = 8;
  localparam int WRITE_CYCLES = WRITE_WAIT_DELAY_MS * CLK_KHZ;
  localparam int ERASE_CYCLES = ERASE_WAIT_DELAY_MS * CLK_KHZ;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    CMD_ERASE = 3'h0,
    CMD_LOCK = 3'h1,
    CMD_FUSE = 3'h2,
    CMD_PWR = 3'h3,
    CMD_DWR = 3'h4
  } smpp_cmd_e;

  typedef struct packed {
    smpp_cmd_e kind;
    logic [IDX_W-1:0] addr;
    logic [7:0] data;
  } smpp_cmd_s;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } smpp_instr_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PWR = 5'h02,
    ST_DERS = 5'h04,
    ST_DWR = 5'h08,
    ST_CERS = 5'h10
  } smpp_state_e;

endpackage

// file: verilog/smpp_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module smpp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= RST;
      dout <= RST;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// file: verilog/smpp_fifo.sv
// Command FIFO with valid and ready on both sides
`timescale 1ns/1ns
module smpp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= push ? wr_r + 1'b1 : wr_r;
      rd_r <= pop ? rd_r + 1'b1 : rd_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: tb/smpp_prog_model.sv
// Behavioural programmer driving the serial programming link
`timescale 1ns/1ns
module smpp_prog_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bench request
  input wire logic go,
  input wire logic [31:0] instr,
  output logic done,
  output logic [31:0] rx,
  // Link pins
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic [31:0] sh_r;
  logic [8:0] cnt_r;
  logic busy_r;

  // ==========================================================
  // Sixteen core cycles per bit, SCK idles low between frames
  always @(posedge core_clk) begin
    if (!nrst) begin
      sck <= 1'b0;
      mosi <= 1'b0;
      busy_r <= 1'b0;
      done <= 1'b0;
      cnt_r <= '0;
      rx <= '0;
    end else if (!busy_r) begin
      done <= 1'b0;
      sck <= 1'b0;
      if (go) begin
        busy_r <= 1'b1;
        sh_r <= instr;
        cnt_r <= '0;
      end
    end else begin
      cnt_r <= cnt_r + 9'h001;
      if (cnt_r[3:0] == 4'h0) begin
        mosi <= sh_r[31];
        sh_r <= {sh_r[30:0], 1'b0};
      end
      if (cnt_r[3:0] == 4'h8) begin
        sck <= 1'b1;
        rx <= {rx[30:0], miso};
      end
      if (cnt_r[3:0] == 4'hF) begin
        sck <= 1'b0;
      end
      if (cnt_r == 9'h1FF) begin
        busy_r <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule

// file: tb/smpp_top_tb.sv
// Self-checking bench of the serial memory programming port
`timescale 1ns/1ns
module smpp_top_tb;
  import smpp_pkg::*;
  localparam int WCYC = 1200;
  localparam int ECYC = 2000;
  localparam logic SPE = 1'b1;
  // Signature values are arbitrary
  localparam logic [7:0] SIGS [4] = '{8'h6B, 8'h2E, 8'hD4, SIG_NONE};
  logic core_clk, nrst, sck_pin, mosi_pin, chip_reset_n, miso_o, miso_oe, go, done;
  logic prog_enabled, write_busy, fast_startup_fuse, cmd_overrun, h;
  logic [1:0] lock_bits;
  logic [31:0] instr, rx, seed;
  logic [11:0] pa;
  logic [7:0] v, v2;
  int bad_count, total_checks;

  smpp_top #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC), .SERIAL_PROG_ENABLE_FUSE(SPE),
    .SIG0(SIGS[0]), .SIG1(SIGS[1]), .SIG2(SIGS[2])) i_smpp_top (
    .core_clk(core_clk), .nrst(nrst), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
    .chip_reset_n(chip_reset_n), .miso_o(miso_o), .miso_oe(miso_oe),
    .prog_enabled(prog_enabled), .write_busy(write_busy), .lock_bits(lock_bits),
    .fast_startup_fuse(fast_startup_fuse), .cmd_overrun(cmd_overrun));
  smpp_prog_model i_smpp_prog_model (.core_clk(core_clk), .nrst(nrst), .go(go),
    .instr(instr), .done(done), .rx(rx), .sck(sck_pin), .mosi(mosi_pin), .miso(miso_o));

  // ==========================================================
  // Helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] fuse_exp(input logic [1:0] lk, input logic fs);
    return {lk[0], lk[1], SPE, FUSE_FILL, fs};
  endfunction

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic rnd();
    seed = xorshift(seed);
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic send(input logic [7:0] b1, b2, b3, b4);
    int n;
    n = 0;
    instr <= {b1, b2, b3, b4};
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) chk1("link frame done", 1'b1, 1'b0);
  endtask

  task automatic idle(input int lim);
    int n;
    n = 0;
    repeat (4) @(posedge core_clk);
    while (write_busy !== 1'b0 && n < lim + 100) begin
      @(posedge core_clk);
      n++;
    end
    chk1("write_busy idle", 1'b0, write_busy);
  endtask

  task automatic rdp(input logic hh, input logic [11:0] a);
    send({OP_PRD, hh, OP_PLOW}, {4'h0, a[11:8]}, a[7:0], 8'h00);
  endtask

  task automatic rdd(input logic [8:0] a);
    send(OP_DRD, {7'h00, a[8]}, a[7:0], 8'h00);
  endtask

  task automatic special(input logic [7:0] b2);
    send(OP_SPECIAL, b2, 8'h00, 8'h00);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic enable();
    send(OP_SPECIAL, B2_ENABLE, 8'h00, 8'h00);
    chk8("enable echo", B2_ENABLE, rx[15:8]);
    chk1("prog_enabled", 1'b1, prog_enabled);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (90000) @(posedge core_clk);
    chk1("watchdog", 1'b0, 1'b1);
    close_out();
  end

  // ==========================================================
  // Tests
  initial begin
    nrst = 1'b0;
    chip_reset_n = 1'b1;
    go = 1'b0;
    instr = '0;
    seed = 32'hA057B31D;
    bad_count = 0;
    total_checks = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk8("lock_bits reset", {6'h00, LOCK_RST}, {6'h00, lock_bits});
    chk1("startup fuse reset", FAST_STARTUP_FUSE_RST, fast_startup_fuse);
    chip_reset_n <= 1'b0;
    repeat (100) @(posedge core_clk);
    chk1("miso_oe", 1'b1, miso_oe);
    special({B2_LOCK_HI, 3'b001});
    chk8("lock before enable", 8'h03, {6'h00, lock_bits});
    enable();
    note("enable");
    special({B2_ERASE, 5'h15});
    idle(ECYC);
    chip_reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk1("enable with pin high", 1'b0, prog_enabled);
    chk1("miso_oe released", 1'b0, miso_oe);
    chip_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    enable();
    for (int i = 0; i < 3; i++) begin
      rnd();
      pa = (i == 0) ? 12'hFFF : seed[11:0];
      rdp(seed[12], pa);
      chk8("program erased", ERASED, rx[7:0]);
      rdd((i == 0) ? 9'h1FF : seed[20:12]);
      chk8("data erased", ERASED, rx[7:0]);
    end
    note("chip erase");
    rnd();
    v = {1'b0, seed[6:1], 1'b1};
    send(OP_DWR, {7'h00, seed[16]}, seed[15:8], v);
    rdd(seed[16:8]);
    chk8("data auto erase", POLL_VALUE_ERASING, rx[7:0]);
    rdd(seed[16:8]);
    chk8("data erased phase", POLL_VALUE_ERASED, rx[7:0]);
    idle(WCYC);
    rdd(seed[16:8]);
    chk8("data written", v, rx[7:0]);
    note("data write");
    for (int i = 0; i < 3; i++) begin
      rnd();
      pa = seed[11:0];
      h = seed[12];
      v = {seed[20:14], 1'b0};
      v2 = seed[31:24];
      send({OP_PWR, h, OP_PLOW}, {4'h0, pa[11:8]}, pa[7:0], v);
      rdp(h, pa);
      chk8("program polling", ERASED, rx[7:0]);
      idle(WCYC);
      send(OP_DWR, {7'h00, pa[8]}, pa[7:0], v2);
      idle(WCYC);
      rdp(h, pa);
      chk8("program written", v, rx[7:0]);
      rdp(~h, pa);
      chk8("program other half", ERASED, rx[7:0]);
      rdd(pa[8:0]);
      chk8("data same index", v2, rx[7:0]);
    end
    note("program write");
    special({B2_FUSE, 1'b0});
    chk1("startup fuse programmed", 1'b0, fast_startup_fuse);
    special({B2_LOCK_HI, 3'b101});
    chk8("lock bit one", 8'h02, {6'h00, lock_bits});
    send(8'hEC, {B2_LOCK_HI, 3'b001}, 8'h00, 8'h00);
    send(OP_FRD, 8'h00, 8'h00, 8'h00);
    chk8("fuse read", fuse_exp(2'b10, 1'b0), rx[7:0]);
    for (int i = 0; i < 4; i++) begin
      send(OP_SIG, 8'h00, i[7:0], 8'h00);
      chk8("signature", SIGS[i], rx[7:0]);
    end
    special({B2_FUSE, 1'b1});
    chk1("startup fuse unprogrammed", 1'b1, fast_startup_fuse);
    special({B2_LOCK_HI, 3'b001});
    chk8("both lock bits", 8'h00, {6'h00, lock_bits});
    send(OP_SIG, 8'h00, 8'h00, 8'h00);
    chk8("signature hidden", SIG_HIDDEN, rx[7:0]);
    send(OP_FRD, 8'h00, 8'h00, 8'h00);
    chk8("fuse read locked", fuse_exp(2'b00, 1'b1), rx[7:0]);
    chk1("cmd_overrun", 1'b0, cmd_overrun);
    note("lock and fuse");
    close_out();
  end
endmodule
